// file: src/esal_top.sv
// Behaviour
// - Five-wire serial memory link with driven clock
// - Supports a 2K-bit serial memory
// - Loaded fields settle before enumeration, done flag
// - Load only when disable strap is low
// - 16-bit words with 7-bit word address
// - Width strap picks word or byte reads
// - First word compared with check code
// - Load starts right after reset when allowed
// - Word 0Ah bit 0 to init flag
// - Word 0Ah bits 3:1 to aux current
// - Word 0Ah bits 4,5 to D1/D2 support
// - Word 0Ah bits 10:6 to power events
// - Word 0Ah bit 11 blocks soft reset
// - Word 10h bits 1:0 to ASPM support
// - Word 10h bits 7:2 to exit latencies
// - Word 12h to UART drive selection
`timescale 1ns/1ps
module esal_top
  import esal_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        eeprom_serial_in,
  output logic             eeprom_serial_out,
  output logic             eeprom_select,
  output logic             eeprom_shift_clock,
  input  wire logic        eeprom_width_strap_n,
  output logic             eeprom_width_sel,
  input  wire logic        autoload_disable,
  input  wire logic        d3hot_to_d0,
  output logic             soft_reset_req,
  output logic             load_done,
  output logic             check_ok,
  output logic             dsi_flag,
  output logic [2:0]       aux_current,
  output logic             d1_support,
  output logic             d2_support,
  output logic [4:0]       power_event_support,
  output logic             no_soft_reset,
  output logic [1:0]       aspm_support,
  output logic [2:0]       l0s_exit_latency,
  output logic [2:0]       l1_exit_latency,
  output logic [15:0]      uart_drive_select
);

  typedef struct packed {
    esal_state_e st;
    logic [3:0]  wait_cnt;
    logic [1:0]  step;
    logic        hi_byte;
    logic        word_mode;
    logic        width_sel;
    logic [15:0] word;
    logic        start;
    logic        check_ok;
    logic        done;
    logic        soft_rst;
    logic        dsi;
    logic [2:0]  aux;
    logic        d1;
    logic        d2;
    logic [4:0]  pev;
    logic        nsr;
    logic [1:0]  aspm;
    logic [2:0]  l0s;
    logic [2:0]  l1;
    logic [15:0] uart;
  } esal_top_s;

  localparam esal_top_s TOP_RST = '{
    st: ESAL_S_STRAP, wait_cnt: 4'h0, step: 2'h0, hi_byte: 1'h0,
    word_mode: 1'h0, width_sel: 1'h0, word: 16'h0000, start: 1'h0,
    check_ok: 1'h0, done: 1'h0, soft_rst: 1'h0,
    dsi: DSI_RST, aux: AUX_RST, d1: D1_RST, d2: D2_RST, pev: PEV_RST,
    nsr: NSR_RST, aspm: ASPM_RST, l0s: L0S_RST, l1: L1_RST,
    uart: UART_RST};

  esal_top_s   cur_ff;
  esal_top_s   nxt_cur;
  logic [2:0]  pins_sync;
  logic        din_sync;
  logic        width_sync_n;
  logic        disable_sync;
  logic [6:0]  word_addr;
  logic [10:0] tx_word;
  logic [4:0]  rx_len;
  logic        rd_done;
  logic [16:0] rd_data;

  // Pin inputs pass two flops before any logic reads them
  esal_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({eeprom_serial_in, eeprom_width_strap_n, autoload_disable}),
    .q      (pins_sync)
  );

  assign din_sync     = pins_sync[2];
  assign width_sync_n = pins_sync[1];
  assign disable_sync = pins_sync[0];

  // Word address for the current step
  always_comb begin
    unique case (cur_ff.step)
      2'h0: word_addr = WA_CHECK;
      2'h1: word_addr = WA_PM;
      2'h2: word_addr = WA_LINK;
      2'h3: word_addr = WA_UART;
    endcase
  end

  // Byte reads append the byte select below the word address
  always_comb begin
    if (cur_ff.word_mode) begin
      tx_word = {RD_CMD, 1'h0, word_addr};
      rx_len  = RX_LEN_WRD;
    end else begin
      tx_word = {RD_CMD, word_addr, cur_ff.hi_byte};
      rx_len  = RX_LEN_BYT;
    end
  end

  // Serial engine makes its own shift clock from clk
  esal_shifter #(
    .HALF_CYC (HALF_CYC)
  ) u_shift (
    .clk      (clk),
    .arst_n   (arst_n),
    .start    (cur_ff.start),
    .tx_word  (tx_word),
    .rx_len   (rx_len),
    .din_sync (din_sync),
    .sclk     (eeprom_shift_clock),
    .cs       (eeprom_select),
    .dout     (eeprom_serial_out),
    .done     (rd_done),
    .rx_data  (rd_data)
  );

  // Load sequencer; fields keep reset values unless a word lands
  always_comb begin
    nxt_cur          = cur_ff;
    nxt_cur.start    = 1'h0;
    // Power manager pulse, same clock domain, no synchroniser
    nxt_cur.soft_rst = d3hot_to_d0 & ~cur_ff.nsr;
    unique case (cur_ff.st)
      ESAL_S_STRAP: begin
        // Straps are caught only after the synchronisers have settled
        nxt_cur.wait_cnt = cur_ff.wait_cnt + 4'h1;
        if (cur_ff.wait_cnt == STRAP_WAIT_CYC) begin
          nxt_cur.word_mode = ~width_sync_n;
          nxt_cur.width_sel = ~width_sync_n;
          if (disable_sync) begin
            nxt_cur.st   = ESAL_S_DONE;
            nxt_cur.done = 1'h1;
          end else begin
            nxt_cur.st    = ESAL_S_ISSUE;
            nxt_cur.step  = 2'h0;
            nxt_cur.start = 1'h1;
          end
        end
      end
      ESAL_S_ISSUE: begin
        nxt_cur.st = ESAL_S_WAIT;
      end
      ESAL_S_WAIT: begin
        if (rd_done) begin
          if (cur_ff.word_mode) begin
            nxt_cur.word = rd_data[15:0];
            nxt_cur.st   = ESAL_S_APPLY;
          end else if (!cur_ff.hi_byte) begin
            // Low byte sits at the even byte address
            nxt_cur.word[7:0] = rd_data[7:0];
            nxt_cur.hi_byte   = 1'h1;
            nxt_cur.start     = 1'h1;
            nxt_cur.st        = ESAL_S_ISSUE;
          end else begin
            nxt_cur.word[15:8] = rd_data[7:0];
            nxt_cur.hi_byte    = 1'h0;
            nxt_cur.st         = ESAL_S_APPLY;
          end
        end
      end
      ESAL_S_APPLY: begin
        nxt_cur.st    = ESAL_S_ISSUE;
        nxt_cur.start = 1'h1;
        nxt_cur.step  = cur_ff.step + 2'h1;
        unique case (cur_ff.step)
          2'h0: begin
            if (cur_ff.word == CHECK_CODE) begin
              nxt_cur.check_ok = 1'h1;
            end else begin
              nxt_cur.st    = ESAL_S_DONE;
              nxt_cur.start = 1'h0;
              nxt_cur.done  = 1'h1;
            end
          end
          2'h1: begin
            nxt_cur.dsi = cur_ff.word[PM_DSI_BIT];
            nxt_cur.aux = cur_ff.word[PM_AUX_LSB +: 3];
            nxt_cur.d1  = cur_ff.word[PM_D1_BIT];
            nxt_cur.d2  = cur_ff.word[PM_D2_BIT];
            nxt_cur.pev = cur_ff.word[PM_PEV_LSB +: 5];
            nxt_cur.nsr = cur_ff.word[PM_NSR_BIT];
          end
          2'h2: begin
            nxt_cur.aspm = cur_ff.word[LK_ASPM_LSB +: 2];
            nxt_cur.l0s  = cur_ff.word[LK_L0S_LSB +: 3];
            nxt_cur.l1   = cur_ff.word[LK_L1_LSB +: 3];
          end
          2'h3: begin
            nxt_cur.uart  = cur_ff.word;
            nxt_cur.st    = ESAL_S_DONE;
            nxt_cur.start = 1'h0;
            nxt_cur.done  = 1'h1;
          end
        endcase
      end
      ESAL_S_DONE: begin
        // Terminal until the next reset; 128 words of 16 bits fit 2K bits
        nxt_cur.done = 1'h1;
      end
      default: begin
        nxt_cur = TOP_RST;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff <= TOP_RST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Everything visible outside comes straight from the state flops
  assign eeprom_width_sel    = cur_ff.width_sel;
  assign soft_reset_req      = cur_ff.soft_rst;
  assign load_done           = cur_ff.done;
  assign check_ok            = cur_ff.check_ok;
  assign dsi_flag            = cur_ff.dsi;
  assign aux_current         = cur_ff.aux;
  assign d1_support          = cur_ff.d1;
  assign d2_support          = cur_ff.d2;
  assign power_event_support = cur_ff.pev;
  assign no_soft_reset       = cur_ff.nsr;
  assign aspm_support        = cur_ff.aspm;
  assign l0s_exit_latency    = cur_ff.l0s;
  assign l1_exit_latency     = cur_ff.l1;
  assign uart_drive_select   = cur_ff.uart;

endmodule

// file: inc/esal_pkg.sv
package esal_pkg;

  // Clock and shift clock timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int SCLK_PERIOD_NS = 320;
  localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // Cycles allowed for the strap synchronisers to settle after reset
  localparam logic [3:0] STRAP_WAIT_CYC = 4'h3;

  // Serial read command: start bit, read opcode, address field
  localparam logic [2:0] RD_CMD     = 3'h6;
  localparam logic [4:0] TX_LEN     = 5'h0B;
  localparam logic [4:0] RX_LEN_WRD = 5'h11;
  localparam logic [4:0] RX_LEN_BYT = 5'h09;

  // Word addresses (byte address halved) and check code
  localparam logic [6:0]  WA_CHECK = 7'h00;
  localparam logic [6:0]  WA_PM    = 7'h05;
  localparam logic [6:0]  WA_LINK  = 7'h08;
  localparam logic [6:0]  WA_UART  = 7'h09;
  localparam logic [15:0] CHECK_CODE = 16'hA868;

  // Field positions inside the power management word
  localparam int PM_DSI_BIT  = 0;
  localparam int PM_AUX_LSB  = 1;
  localparam int PM_D1_BIT   = 4;
  localparam int PM_D2_BIT   = 5;
  localparam int PM_PEV_LSB  = 6;
  localparam int PM_NSR_BIT  = 11;

  // Field positions inside the link word
  localparam int LK_ASPM_LSB = 0;
  localparam int LK_L0S_LSB  = 2;
  localparam int LK_L1_LSB   = 5;

  // Values held until a load replaces them
  localparam logic        DSI_RST  = 1'h0;
  localparam logic [2:0]  AUX_RST  = 3'h7;
  localparam logic        D1_RST   = 1'h1;
  localparam logic        D2_RST   = 1'h1;
  localparam logic [4:0]  PEV_RST  = 5'h08;
  localparam logic        NSR_RST  = 1'h1;
  localparam logic [1:0]  ASPM_RST = 2'h3;
  localparam logic [2:0]  L0S_RST  = 3'h3;
  localparam logic [2:0]  L1_RST   = 3'h0;
  localparam logic [15:0] UART_RST = 16'h0000;

  typedef enum logic [2:0] {
    ESAL_S_STRAP,
    ESAL_S_ISSUE,
    ESAL_S_WAIT,
    ESAL_S_APPLY,
    ESAL_S_DONE
  } esal_state_e;

  typedef enum logic [1:0] {
    ESAL_P_IDLE,
    ESAL_P_LOW,
    ESAL_P_HIGH,
    ESAL_P_END
  } esal_phase_e;

endpackage

// file: src/esal_sync.sv
`timescale 1ns/1ps
module esal_sync
  import esal_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } esal_sync_s;

  esal_sync_s cur_ff;
  esal_sync_s nxt_cur;

  // Two stages; only the second stage is visible outside
  always_comb begin
    nxt_cur    = cur_ff;
    nxt_cur.s1 = d;
    nxt_cur.s2 = cur_ff.s1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign q = cur_ff.s2;

endmodule

// file: src/esal_shifter.sv
`timescale 1ns/1ps
module esal_shifter
  import esal_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        start,
  input  wire logic [10:0] tx_word,
  input  wire logic [4:0]  rx_len,
  input  wire logic        din_sync,
  output logic             sclk,
  output logic             cs,
  output logic             dout,
  output logic             done,
  output logic [16:0]      rx_data
);

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

  typedef struct packed {
    esal_phase_e ph;
    logic [7:0]  div;
    logic [4:0]  bcnt;
    logic [4:0]  rlen;
    logic [10:0] tx;
    logic [16:0] rx;
    logic        sclk;
    logic        cs;
    logic        dout;
    logic        done;
  } esal_shift_s;

  localparam esal_shift_s SHIFT_RST = '{
    ph: ESAL_P_IDLE, div: 8'h00, bcnt: 5'h00, rlen: 5'h00, tx: 11'h000,
    rx: 17'h00000, sclk: 1'h0, cs: 1'h0, dout: 1'h0, done: 1'h0};

  esal_shift_s cur_ff;
  esal_shift_s nxt_cur;

  // Select, command bits out on low phase, data sampled at end of high
  always_comb begin
    nxt_cur      = cur_ff;
    nxt_cur.done = 1'h0;
    unique case (cur_ff.ph)
      ESAL_P_IDLE: begin
        if (start) begin
          nxt_cur.ph   = ESAL_P_LOW;
          nxt_cur.cs   = 1'h1;
          nxt_cur.tx   = tx_word;
          nxt_cur.dout = tx_word[10];
          nxt_cur.rlen = rx_len;
          nxt_cur.bcnt = 5'h00;
          nxt_cur.div  = 8'h00;
        end
      end
      ESAL_P_LOW: begin
        nxt_cur.div = cur_ff.div + 8'h01;
        if (cur_ff.div == HALF_LAST) begin
          nxt_cur.div  = 8'h00;
          nxt_cur.sclk = 1'h1;
          nxt_cur.ph   = ESAL_P_HIGH;
        end
      end
      ESAL_P_HIGH: begin
        nxt_cur.div = cur_ff.div + 8'h01;
        if (cur_ff.div == HALF_LAST) begin
          // Synchronised input lags two cycles, so sample late in the phase
          nxt_cur.div  = 8'h00;
          nxt_cur.sclk = 1'h0;
          nxt_cur.bcnt = cur_ff.bcnt + 5'h01;
          if (cur_ff.bcnt >= TX_LEN) begin
            nxt_cur.rx = {cur_ff.rx[15:0], din_sync};
          end
          nxt_cur.tx   = {cur_ff.tx[9:0], 1'h0};
          nxt_cur.dout = cur_ff.tx[9] & (cur_ff.bcnt < (TX_LEN - 5'h01));
          if (cur_ff.bcnt == (TX_LEN + cur_ff.rlen - 5'h01)) begin
            nxt_cur.ph = ESAL_P_END;
          end else begin
            nxt_cur.ph = ESAL_P_LOW;
          end
        end
      end
      ESAL_P_END: begin
        // Hold select one half period after the last clock
        nxt_cur.div = cur_ff.div + 8'h01;
        if (cur_ff.div == HALF_LAST) begin
          nxt_cur.div  = 8'h00;
          nxt_cur.cs   = 1'h0;
          nxt_cur.done = 1'h1;
          nxt_cur.ph   = ESAL_P_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff <= SHIFT_RST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign sclk    = cur_ff.sclk;
  assign cs      = cur_ff.cs;
  assign dout    = cur_ff.dout;
  assign done    = cur_ff.done;
  assign rx_data = cur_ff.rx;

endmodule

// file: dv/esal_eeprom_model.sv
`timescale 1ns/1ps
module esal_eeprom_model
  import esal_pkg::*;
(
  input  wire logic clk,
  input  wire logic eeprom_select,
  input  wire logic eeprom_shift_clock,
  input  wire logic eeprom_serial_out,
  input  wire logic eeprom_width_sel,
  output logic      eeprom_serial_in
);
  logic [15:0] mem [128];
  logic [10:0] cmd;
  logic [15:0] sh;
  int          n;

  // Deselected: output wanders every cycle, so a stale bit never helps
  always @(posedge clk) begin
    if (!eeprom_select) begin
      n = 0;
      eeprom_serial_in <= ~eeprom_serial_in;
    end
  end

  // Command in, then a dummy zero and the data MSB first
  always @(posedge eeprom_shift_clock) begin
    if (eeprom_select) begin
      n = n + 1;
      if (n <= 11) cmd = {cmd[9:0], eeprom_serial_out};
      if (n == 11 && cmd[10:8] == RD_CMD) begin
        if (eeprom_width_sel) sh = mem[cmd[6:0]];
        else sh = {cmd[0] ? mem[cmd[7:1]][15:8] : mem[cmd[7:1]][7:0], 8'h00};
      end
      if (n == 12) eeprom_serial_in <= 1'b0;
      else if (n > 12) begin
        eeprom_serial_in <= sh[15];
        sh = {sh[14:0], 1'b0};
      end
    end
  end

  // Known level before the first clock
  initial eeprom_serial_in = 1'b0;
endmodule

// file: dv/esal_asserts.sv
`timescale 1ns/1ps
module esal_asserts
  import esal_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        eeprom_serial_out,
  input wire logic        eeprom_select,
  input wire logic        eeprom_shift_clock,
  input wire logic        autoload_disable,
  input wire logic        d3hot_to_d0,
  input wire logic        soft_reset_req,
  input wire logic        load_done,
  input wire logic        check_ok,
  input wire logic        no_soft_reset,
  input wire logic [2:0]  aux_current,
  input wire logic [15:0] uart_drive_select
);
  logic [8:0] sel_cnt_ff;
  logic [3:0] age_ff;

  // Frame length, cleared while deselected, and saturating count of cycles since reset release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_cnt_ff <= 9'h000;
      age_ff     <= 4'h0;
    end else begin
      sel_cnt_ff <= eeprom_select ? sel_cnt_ff + 9'h001 : 9'h000;
      age_ff     <= (age_ff == 4'hF) ? age_ff : age_ff + 4'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_clk_idle; !eeprom_select |-> !eeprom_shift_clock; endproperty
  a_clk_idle: assert property (p_clk_idle)
    else $error("shift clock moves while deselected");
  property p_start_bit;
    $rose(eeprom_select) |-> (eeprom_serial_out && !eeprom_shift_clock)[*3]
      ##[1:13] $rose(eeprom_shift_clock);
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("read frame does not open with start bit");
  property p_sel_len; eeprom_select |-> sel_cnt_ff <= 9'(58 * HALF_CYC);
  endproperty
  a_sel_len: assert property (p_sel_len)
    else $error("select held longer than one word read");
  property p_start;
    age_ff == 4'hA |-> (autoload_disable ? load_done : eeprom_select);
  endproperty
  a_start: assert property (p_start)
    else $error("load did not start right after reset");
  property p_done_quiet; load_done |=> load_done && !eeprom_select;
  endproperty
  a_done_quiet: assert property (p_done_quiet)
    else $error("link active or done dropped after load");
  property p_disabled; autoload_disable && load_done |-> !check_ok;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("check passed although load disabled");
  property p_soft_req; d3hot_to_d0 && !no_soft_reset |=> soft_reset_req;
  endproperty
  a_soft_req: assert property (p_soft_req)
    else $error("soft reset request missing");
  property p_defaults;
    load_done && !check_ok |->
      aux_current == AUX_RST && uart_drive_select == UART_RST;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("fields left defaults without a valid load");
endmodule

bind esal_top esal_asserts #(.HALF_CYC(HALF_CYC)) u_asserts (
  .clk, .arst_n, .eeprom_serial_out, .eeprom_select, .eeprom_shift_clock,
  .autoload_disable, .d3hot_to_d0, .soft_reset_req, .load_done, .check_ok,
  .no_soft_reset, .aux_current, .uart_drive_select
);

// file: dv/esal_top_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
  mismatches++; $display("mismatch at %0t: got %0h exp %0h", \
  $time, got, exp); end end
module esal_top_bench
  import esal_pkg::*;
;
  typedef struct packed {
    logic        strap_n;
    logic        dis;
    logic [15:0] chk;
    logic [15:0] pm;
    logic [15:0] lk;
    logic [15:0] ua;
  } esal_row_s;

  logic        clk;
  logic        arst_n;
  logic        eeprom_serial_in;
  logic        eeprom_serial_out;
  logic        eeprom_select;
  logic        eeprom_shift_clock;
  logic        eeprom_width_strap_n;
  logic        eeprom_width_sel;
  logic        autoload_disable;
  logic        d3hot_to_d0;
  logic        soft_reset_req;
  logic        load_done;
  logic        check_ok;
  logic        dsi_flag;
  logic [2:0]  aux_current;
  logic        d1_support;
  logic        d2_support;
  logic [4:0]  power_event_support;
  logic        no_soft_reset;
  logic [1:0]  aspm_support;
  logic [2:0]  l0s_exit_latency;
  logic [2:0]  l1_exit_latency;
  logic [15:0] uart_drive_select;
  int          mismatches;
  int          checked;
  int          cyc;
  int          nreads;
  int          nclk;
  esal_row_s   rows [6];

  esal_top #(.HALF_CYC(SCLK_HALF_CYC)) DUT (
    .clk, .arst_n, .eeprom_serial_in, .eeprom_serial_out, .eeprom_select,
    .eeprom_shift_clock, .eeprom_width_strap_n, .eeprom_width_sel,
    .autoload_disable, .d3hot_to_d0, .soft_reset_req, .load_done,
    .check_ok, .dsi_flag, .aux_current, .d1_support, .d2_support,
    .power_event_support, .no_soft_reset, .aspm_support,
    .l0s_exit_latency, .l1_exit_latency, .uart_drive_select
  );

  esal_eeprom_model u_mem (
    .clk, .eeprom_select, .eeprom_shift_clock, .eeprom_serial_out,
    .eeprom_width_sel, .eeprom_serial_in
  );

  // Core clock, and counters of link activity
  always #20 clk = ~clk;
  always @(posedge eeprom_select) nreads++;
  always @(posedge eeprom_shift_clock) nclk++;

  // Hang guard, far above the longest expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Straps settle inside the reset window, as they must
  task automatic do_reset(input esal_row_s r);
    arst_n               <= 1'b0;
    eeprom_width_strap_n <= r.strap_n;
    autoload_disable     <= r.dis;
    repeat (16) @(posedge clk);
    nreads = 0;
    nclk   = 0;
    arst_n <= 1'b1;
  endtask

  task automatic run_row(input esal_row_s r);
    logic        good;
    logic [15:0] p;
    logic [15:0] k;
    int          rd;
    good = (r.chk === CHECK_CODE) && !r.dis;
    p = good ? r.pm : {4'h0, NSR_RST, PEV_RST, D2_RST, D1_RST, AUX_RST,
                       DSI_RST};
    k = good ? r.lk : {8'h00, L1_RST, L0S_RST, ASPM_RST};
    rd = r.dis ? 0 : (r.chk === CHECK_CODE ? 4 : 1) * (r.strap_n ? 2 : 1);
    for (int i = 0; i < 128; i++) u_mem.mem[i] = 16'hC3C3;
    u_mem.mem[WA_CHECK] = r.chk;
    u_mem.mem[WA_PM]    = r.pm;
    u_mem.mem[WA_LINK]  = r.lk;
    u_mem.mem[WA_UART]  = r.ua;
    @(posedge clk);
    do_reset(r);
    for (int i = 0; i < 6000 && load_done !== 1'b1; i++) @(negedge clk);
    `CHK(load_done, 1'b1)
    `CHK(check_ok, good)
    `CHK(eeprom_width_sel, !r.strap_n)
    `CHK(nreads, rd)
    `CHK(nclk, rd * (r.strap_n ? 20 : 28))
    `CHK(dsi_flag, p[0])
    `CHK(aux_current, p[3:1])
    `CHK({d2_support, d1_support}, p[5:4])
    `CHK(power_event_support, p[10:6])
    `CHK(aspm_support, k[1:0])
    `CHK({l1_exit_latency, l0s_exit_latency}, k[7:2])
    `CHK(uart_drive_select, good ? r.ua : UART_RST)
    `CHK(no_soft_reset, p[11])
    @(posedge clk);
    d3hot_to_d0 <= 1'b1;
    @(posedge clk);
    d3hot_to_d0 <= 1'b0;
    @(negedge clk);
    `CHK(soft_reset_req, !p[11])
  endtask

  // Table of loads, then a reset mid-load and a late strap change
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    eeprom_width_strap_n = 1'b0;
    autoload_disable = 1'b0;
    d3hot_to_d0 = 1'b0;
    mismatches = 0;
    checked = 0;
    cyc = 0;
    rows = '{'{1'b0, 1'b0, 16'hA868, 16'h0000, 16'h0000, 16'hA55A},
             '{1'b1, 1'b0, 16'hA868, 16'h0FFF, 16'h00FF, 16'h5AC3},
             '{1'b0, 1'b0, 16'hA868, 16'h0A95, 16'h00B6, 16'h1234},
             '{1'b1, 1'b0, 16'hA869, 16'h0000, 16'h0000, 16'hFFFF},
             '{1'b0, 1'b1, 16'hA868, 16'h0000, 16'h0000, 16'hFFFF},
             '{1'b1, 1'b0, 16'h68A8, 16'h0000, 16'h0000, 16'hFFFF}};
    foreach (rows[i]) run_row(rows[i]);
    @(posedge clk);
    do_reset(rows[1]);
    repeat (300) @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    `CHK({load_done, eeprom_select, uart_drive_select}, 18'h00000)
    run_row(rows[2]);
    @(posedge clk);
    eeprom_width_strap_n <= 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    `CHK(eeprom_width_sel, 1'b1)
    stop_test();
  end
endmodule
